// *** pkg/chr_pkg.sv ***
// coder host control registers: offsets, field layouts, reset values and carriers.
// assumes the host bus is sampled synchronously to core_clk.
package chr_pkg;

  // ************************************************************
  // register offsets (4-bit host address)
  // ************************************************************
  localparam logic [3:0] OFS_STATUS  = 4'h2;
  localparam logic [3:0] OFS_IRQ_EN  = 4'h3;
  localparam logic [3:0] OFS_PPR_LO  = 4'h4;
  localparam logic [3:0] OFS_PPR_HI  = 4'h5;
  localparam logic [3:0] OFS_ROW_LO  = 4'h6;
  localparam logic [3:0] OFS_ROW_HI  = 4'h7;
  localparam logic [3:0] OFS_DONE_LO = 4'h8;
  localparam logic [3:0] OFS_DONE_HI = 4'h9;
  localparam logic [3:0] OFS_BUF_LO  = 4'hA;
  localparam logic [3:0] OFS_BUF_HI  = 4'hB;
  localparam logic [3:0] OFS_MARKER  = 4'hC;
  localparam logic [3:0] OFS_FUNC    = 4'hD;

  // ************************************************************
  // values
  // ************************************************************
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  PPR_HI_MASK      = 8'h3F;
  localparam logic [7:0]  IRQ_EN_MASK      = 8'h8F;
  localparam logic [7:0]  PAD_BYTE         = 8'h00;
  localparam logic [7:0]  STRIPE_END_NORMAL     = 8'h02;
  localparam logic [7:0]  STRIPE_END_WITH_RESET = 8'h03;
  localparam logic [7:0]  MARKER_ABORT     = 8'h04;
  localparam logic [6:0]  CTX_STATE_MAX    = 7'h70;
  localparam logic [15:0] ROW_COUNT_MAX    = 16'hFFFF;
  localparam int          FIFO_DEPTH       = 4;
  localparam int          FIFO_WIDTH       = 16;

  // ************************************************************
  // field layouts (msb first)
  // ************************************************************
  typedef struct packed {
    logic ff_count_overflow;   // d4
    logic request_pending;     // d3
    logic marker_seen_flag;    // d2
    logic xfer_ready_flag;     // d1
    logic process_done_flag;   // d0
  } chr_status_t;

  typedef struct packed {
    logic       halt_on_marker;       // d7
    logic [2:0] unused;
    logic       overflow_irq_enable;  // d3
    logic       marker_irq_enable;    // d2
    logic       ready_irq_enable;     // d1
    logic       finish_irq_enable;    // d0
  } chr_irq_en_t;

  typedef struct packed {
    logic typical_predict;   // d7
    logic keep_ref_row;      // d6
    logic skip_first_byte;   // d5
    logic wide_or_merge;     // d4
    logic wide_halve;        // d3
    logic tall_halve;        // d2
    logic wide_double;       // d1
    logic tall_double;       // d0
  } chr_func_t;

  typedef struct packed {
    logic        cs_n;
    logic        wr_n;
    logic        rd_n;
    logic        bhe_n;
    logic [3:0]  addr;
    logic [15:0] data;
  } chr_host_bus_t;

  typedef struct packed {
    chr_irq_en_t irq_en;
    logic [7:0]  pixels_per_row_low;
    logic [7:0]  pixels_per_row_high;
    logic [7:0]  row_target_low;
    logic [7:0]  row_target_high;
    logic [7:0]  end_marker_value;
    chr_func_t   func;
  } chr_regs_t;

endpackage

// *** rtl/chr_regs.sv ***
// host control register bank of the bi-level coder, plus its 4-word code FIFO.
// assumes host strobes are synchronous to core_clk and the coding core drives
// the status levels, marker, row and code-byte events.
`timescale 1ns/1ps

// ************************************************************
// fifo
// ************************************************************
module chr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } chr_fifo_st_t;

  chr_fifo_st_t st_r;
  chr_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready  = (st_r.cnt != CW'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = ptr_inc(st_r.wp);
    end
    if (pop) begin
      st_nxt.rp = ptr_inc(st_r.rp);
    end
    if (push && !pop) begin
      st_nxt.cnt = CW'(st_r.cnt + 1'b1);
    end else if (pop && !push) begin
      st_nxt.cnt = CW'(st_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

module chr_regs
  import chr_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  chr_host_bus_t      host,
  input  wire logic          wide_host_bus,
  output logic [15:0]        host_data_out,
  output logic               host_data_oe_n,
  output logic               irq_out,
  input  wire logic          decoding,
  input  wire logic          ctx_mode,
  input  wire logic          start_cmd,
  input  wire logic          first_stripe,
  input  chr_status_t        core_status,
  input  wire logic          marker_valid,
  input  wire logic [7:0]    marker_code,
  input  wire logic          row_done,
  output logic [15:0]        wr_data,
  output logic [1:0]         wr_lanes,
  output logic               wr_valid,
  input  wire logic [7:0]    code_byte,
  input  wire logic          code_valid,
  input  wire logic          code_last,
  output logic               code_ready,
  output logic               halt_decode,
  output logic               rows_reached,
  output logic               line_clear,
  output chr_func_t          options,
  output logic [7:0]         end_marker_value,
  output logic [13:0]        pixels_per_row
);

  typedef struct packed {
    chr_regs_t   regs;
    logic        wr_n_prev;
    logic        rd_n_prev;
    logic [15:0] rdata;
    logic        oe_n;
    logic        irq;
    logic        paused;
    logic [7:0]  found_marker_value;
    logic [15:0] rows_done;
    logic        reached;
    logic        discard;
    logic        clear;
    logic [15:0] wdata;
    logic [1:0]  lanes;
    logic        wvalid;
    logic [7:0]  lo_byte;
    logic        have_lo;
    logic [15:0] word;
    logic        word_valid;
    logic        cready;
    chr_func_t   opts;
  } chr_state_t;

  chr_state_t  st_r;
  chr_state_t  st_nxt;
  logic        wr_evt;
  logic        rd_evt;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_pop;
  logic [15:0] f_out_data;
  chr_status_t stat;
  logic        rows_done_is_zero;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic chr_regs_t reg_write(input chr_regs_t r, input logic [3:0] a,
                                          input logic [7:0] v);
    chr_regs_t n;
    n = r;
    case (a)
      OFS_IRQ_EN: n.irq_en              = chr_irq_en_t'(v & IRQ_EN_MASK);
      OFS_PPR_LO: n.pixels_per_row_low  = v;
      OFS_PPR_HI: n.pixels_per_row_high = v & PPR_HI_MASK;
      OFS_ROW_LO: n.row_target_low      = v;
      OFS_ROW_HI: n.row_target_high     = v;
      OFS_MARKER: n.end_marker_value    = v;
      OFS_FUNC:   n.func                = chr_func_t'(v);
      default:    n = r;
    endcase
    reg_write = n;
  endfunction

  function automatic logic [7:0] reg_read(input chr_state_t s, input logic [3:0] a,
                                          input chr_status_t sv, input logic [15:0] head);
    case (a)
      OFS_STATUS:  reg_read = {3'b000, sv};
      OFS_IRQ_EN:  reg_read = s.regs.irq_en;
      OFS_PPR_LO:  reg_read = s.regs.pixels_per_row_low;
      OFS_PPR_HI:  reg_read = s.regs.pixels_per_row_high;
      OFS_ROW_LO:  reg_read = s.regs.row_target_low;
      OFS_ROW_HI:  reg_read = s.regs.row_target_high;
      OFS_DONE_LO: reg_read = s.rows_done[7:0];
      OFS_DONE_HI: reg_read = s.rows_done[15:8];
      OFS_BUF_LO:  reg_read = head[7:0];
      OFS_BUF_HI:  reg_read = ctx_mode ? REG_RESET : head[15:8];
      OFS_MARKER:  reg_read = s.found_marker_value;
      OFS_FUNC:    reg_read = s.regs.func;
      default:     reg_read = REG_RESET;
    endcase
  endfunction

  // ************************************************************
  // host strobes and status view
  // ************************************************************
  // act on the assertion edge only, so long strobes never double-pop the fifo
  assign wr_evt = !host.cs_n && !host.wr_n && st_r.wr_n_prev;
  assign rd_evt = !host.cs_n && !host.rd_n && st_r.rd_n_prev;
  assign f_pop  = rd_evt && (host.addr == OFS_BUF_LO) && f_out_valid;

  always_comb begin
    stat                 = core_status;
    stat.request_pending = st_r.irq;
  end

  chr_fifo #(
    .W     (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_code_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (st_r.word_valid),
    .in_ready  (f_in_ready),
    .in_data   (st_r.word),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [15:0] tgt;
    logic        hi_en;
    logic [3:0]  hi_a;
    logic [15:0] wd;
    logic [1:0]  ln;
    tgt    = 16'h0000;
    hi_en  = 1'b0;
    hi_a   = 4'h0;
    wd     = 16'h0000;
    ln     = 2'b00;
    st_nxt = st_r;

    st_nxt.wr_n_prev = host.wr_n || host.cs_n;
    st_nxt.rd_n_prev = host.rd_n || host.cs_n;
    st_nxt.oe_n      = host.cs_n || host.rd_n;
    st_nxt.wvalid    = 1'b0;
    st_nxt.clear     = 1'b0;
    hi_en            = wide_host_bus && !host.bhe_n;
    hi_a             = host.addr | 4'h1;

    // register writes: low lane at the address unless it is odd on a wide bus, high lane at the odd partner
    if (wr_evt) begin
      if (!wide_host_bus || !host.addr[0]) begin
        st_nxt.regs = reg_write(st_nxt.regs, host.addr, host.data[7:0]);
      end
      if (hi_en) begin
        st_nxt.regs = reg_write(st_nxt.regs, hi_a, host.data[15:8]);
      end
    end

    if (rd_evt) begin
      st_nxt.rdata = {8'h00, reg_read(st_r, host.addr, stat, f_out_data)};
      if (hi_en) begin
        st_nxt.rdata[15:8] = reg_read(st_r, hi_a, stat, f_out_data);
      end
    end

    // write buffer toward the core; context words carry only the low byte
    if (wr_evt && host.addr == OFS_BUF_LO) begin
      wd = host.data;
      ln = {hi_en, 1'b1};
      if (ctx_mode || !wide_host_bus) begin
        wd = {8'h00, host.data[7:0]};
        ln = 2'b01;
      end
      if (st_r.discard) begin
        ln             = ln & 2'b10;
        st_nxt.discard = 1'b0;
      end
      st_nxt.wdata  = wd;
      st_nxt.lanes  = ln;
      st_nxt.wvalid = (ln != 2'b00);
    end

    // interrupt: enables d0..d3 gate status d0, d1, d2, d4
    st_nxt.irq = |({st_nxt.regs.irq_en.overflow_irq_enable,
                    st_nxt.regs.irq_en.marker_irq_enable,
                    st_nxt.regs.irq_en.ready_irq_enable,
                    st_nxt.regs.irq_en.finish_irq_enable} &
                   {core_status.ff_count_overflow, core_status.marker_seen_flag,
                    core_status.xfer_ready_flag, core_status.process_done_flag});

    // marker capture and halt
    if (decoding && marker_valid) begin
      st_nxt.found_marker_value = marker_code;
      if (st_nxt.regs.irq_en.halt_on_marker) begin
        st_nxt.paused = 1'b1;
      end
    end
    if (!st_nxt.regs.irq_en.halt_on_marker || !decoding) begin
      st_nxt.paused = 1'b0;
    end

    // row counting; a start begins a fresh relative count
    if (start_cmd) begin
      st_nxt.rows_done = 16'h0000;
      st_nxt.discard   = decoding && first_stripe && st_nxt.regs.func.skip_first_byte;
      st_nxt.clear     = !st_nxt.regs.func.keep_ref_row;
    end else if (row_done) begin
      st_nxt.rows_done = 16'(st_r.rows_done + 16'h0001);
    end
    tgt            = {st_nxt.regs.row_target_high, st_nxt.regs.row_target_low};
    st_nxt.reached = (tgt != 16'h0000) && (st_nxt.rows_done == tgt);

    // options reach the core only in the mode where they mean something
    st_nxt.opts                 = st_nxt.regs.func;
    st_nxt.opts.tall_double     = st_nxt.regs.func.tall_double && decoding;
    st_nxt.opts.wide_double     = st_nxt.regs.func.wide_double && decoding;
    st_nxt.opts.tall_halve      = st_nxt.regs.func.tall_halve && !decoding;
    st_nxt.opts.wide_halve      = st_nxt.regs.func.wide_halve && !decoding;
    st_nxt.opts.wide_or_merge   = st_nxt.regs.func.wide_or_merge && !decoding;
    st_nxt.opts.skip_first_byte = st_nxt.regs.func.skip_first_byte && decoding;
    st_nxt.opts.typical_predict = st_nxt.regs.func.typical_predict;

    // code byte packer: pairs bytes on a wide bus outside context mode, pads an odd tail
    if (st_r.word_valid && f_in_ready) begin
      st_nxt.word_valid = 1'b0;
    end
    if (code_valid && st_r.cready) begin
      if (!wide_host_bus || ctx_mode) begin
        st_nxt.word       = {8'h00, code_byte};
        st_nxt.word_valid = 1'b1;
      end else if (st_r.have_lo) begin
        st_nxt.word       = {code_byte, st_r.lo_byte};
        st_nxt.word_valid = 1'b1;
        st_nxt.have_lo    = 1'b0;
      end else if (code_last) begin
        st_nxt.word       = {PAD_BYTE, code_byte};
        st_nxt.word_valid = 1'b1;
      end else begin
        st_nxt.lo_byte = code_byte;
        st_nxt.have_lo = 1'b1;
      end
    end
    st_nxt.cready = !st_nxt.word_valid;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r           <= '0;
      st_r.wr_n_prev <= 1'b1;
      st_r.rd_n_prev <= 1'b1;
      st_r.oe_n      <= 1'b1;
      st_r.clear     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign host_data_out    = st_r.rdata;
  assign host_data_oe_n   = st_r.oe_n;
  assign irq_out          = st_r.irq;
  assign wr_data          = st_r.wdata;
  assign wr_lanes         = st_r.lanes;
  assign wr_valid         = st_r.wvalid;
  assign code_ready       = st_r.cready;
  assign halt_decode      = st_r.paused;
  assign rows_reached     = st_r.reached;
  assign line_clear       = st_r.clear;
  assign options          = st_r.opts;
  assign end_marker_value = st_r.regs.end_marker_value;
  assign pixels_per_row   = {st_r.regs.pixels_per_row_high[5:0], st_r.regs.pixels_per_row_low};

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_irq_raise: assert property ((st_r.regs.irq_en.finish_irq_enable &&
    core_status.process_done_flag && !start_cmd) ##1 st_r.regs.irq_en.finish_irq_enable
    |-> irq_out) else $error("finish status enabled but no interrupt");
  a_irq_masked: assert property ((st_r.regs.irq_en[3:0] == 4'h0) |-> !irq_out)
    else $error("interrupt raised while all causes masked");
  a_halt_marker: assert property ((decoding && marker_valid &&
    st_r.regs.irq_en.halt_on_marker && !wr_evt) |=> halt_decode)
    else $error("marker did not halt decode");
  a_halt_resume: assert property ($fell(halt_decode) |->
    ($past(wr_evt) || !$past(decoding) || $past(srst))) else $error("halt dropped without write");
  a_rows_clear: assert property (start_cmd |=> rows_done_is_zero)
    else $error("rows done not cleared by start");
  a_rows_step: assert property ((row_done && !start_cmd) |=>
    st_r.rows_done == 16'($past(st_r.rows_done) + 16'h0001)) else $error("row count step wrong");
  a_marker_keep: assert property ((decoding && marker_valid) |=>
    st_r.found_marker_value == $past(marker_code)) else $error("marker code altered");
  a_pad_tail: assert property ((code_valid && code_ready && code_last && wide_host_bus &&
    !ctx_mode && !st_r.have_lo) |=> (st_r.word_valid && st_r.word[15:8] == PAD_BYTE))
    else $error("odd tail not padded");
  a_skip_byte: assert property ((st_r.discard && wr_evt && host.addr == OFS_BUF_LO &&
    !wide_host_bus) |=> !wr_valid) else $error("first byte not discarded");

  assign rows_done_is_zero = (st_r.rows_done == 16'h0000);

  c_marker_halt: cover property (halt_decode ##[1:20] !halt_decode);
  c_pad_word:    cover property (st_r.word_valid && st_r.word[15:8] == PAD_BYTE && wide_host_bus);
  c_fifo_full:   cover property (!f_in_ready ##[1:10] f_pop);
  c_irq_event:   cover property (!irq_out ##1 irq_out);
endmodule

// *** verification/chr_core_model.sv ***
// core-side source of code bytes for the register bank's stream input.
// assumes code_ready is sampled on rising edges of core_clk.
`timescale 1ns/1ps
module chr_core_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] last_byte,
  input  wire logic       code_ready,
  output logic [7:0]      code_byte,
  output logic            code_valid,
  output logic            code_last
);
  // ************************************************************
  // two data bytes then the end marker, each held until taken
  // ************************************************************
  logic first_r = 1'b1;
  initial begin
    code_byte = 8'h5A;
    code_valid = 1'b0;
    code_last = 1'b0;
  end
  always @(posedge core_clk) begin
    if (go && !code_valid) begin
      code_valid <= 1'b1;
      code_byte <= 8'hA0;
      first_r <= 1'b1;
    end else if (code_valid && code_ready) begin
      // released byte lane shows the inverse so stale data never matches
      code_byte <= code_last ? ~code_byte : (first_r ? 8'hA1 : last_byte);
      code_last <= !code_last && !first_r;
      code_valid <= !code_last;
      first_r <= 1'b0;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench of the coder host control registers.
// assumes a synchronous host bus and the core byte source model beside it.
`timescale 1ns/1ps
module tb_top;
  import chr_pkg::*;
  logic core_clk = 0, srst = 1, wide = 0, decoding = 0, start_cmd = 0, go = 0;
  logic marker_valid = 0, row_done = 0, code_ready, code_valid, code_last;
  logic irq_out, halt_decode, rows_reached, host_data_oe_n;
  logic ctx = 0, first_stripe = 0, wr_valid, line_clear;
  logic [1:0] wr_lanes, wr_ln = 0;
  logic [15:0] wr_data, wr_dat = 0, wr_cnt = 0;
  chr_func_t options;
  localparam int P_MARK = 0, P_START = 1, P_ROW = 2, P_GO = 3;
  logic [7:0] marker_code = 8'h00, code_byte, end_marker_value;
  logic [13:0] pixels_per_row;
  logic [15:0] host_data_out, q;
  chr_status_t core_status = '0;
  chr_host_bus_t host = '{cs_n: 1, wr_n: 1, rd_n: 1, bhe_n: 1, addr: 0, data: 0};
  int n_errors = 0, cmp_count = 0;

  chr_regs i_dut (.core_clk(core_clk), .srst(srst), .host(host), .wide_host_bus(wide),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n), .irq_out(irq_out),
    .decoding(decoding), .ctx_mode(ctx), .start_cmd(start_cmd), .first_stripe(first_stripe),
    .core_status(core_status), .marker_valid(marker_valid), .marker_code(marker_code),
    .row_done(row_done), .wr_data(wr_data), .wr_lanes(wr_lanes), .wr_valid(wr_valid),
    .code_byte(code_byte),
    .code_valid(code_valid), .code_last(code_last), .code_ready(code_ready),
    .halt_decode(halt_decode), .rows_reached(rows_reached), .line_clear(line_clear),
    .options(options),
    .end_marker_value(end_marker_value), .pixels_per_row(pixels_per_row));
  chr_core_model i_core (.core_clk(core_clk), .go(go), .last_byte(end_marker_value),
    .code_ready(code_ready), .code_byte(code_byte), .code_valid(code_valid),
    .code_last(code_last));

  initial forever #4 core_clk = ~core_clk;
  // capture every write-buffer word handed to the core, it stands one cycle only
  always @(posedge core_clk) begin
    if (wr_valid) begin
      wr_cnt <= wr_cnt + 16'h0001;
      wr_dat <= wr_data;
      wr_ln  <= wr_lanes;
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one strobe per access, released for an edge before the next one
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    host.cs_n <= 1'b0;
    host.addr <= a;
    host.data <= {d, d};
    host.bhe_n <= !wide;
    if (w) host.wr_n <= 1'b0;
    else host.rd_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 q = host_data_out;
    if (!w) chk("read enable", host_data_oe_n, 1'b0);
    @(posedge core_clk);
    host.cs_n <= 1'b1;
    host.wr_n <= 1'b1;
    host.rd_n <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic pulse(int k);
    case (k)
      P_MARK:  marker_valid <= 1'b1;
      P_START: start_cmd <= 1'b1;
      P_ROW:   row_done <= 1'b1;
      default: go <= 1'b1;
    endcase
    @(posedge core_clk);
    {marker_valid, start_cmd, row_done, go} <= 4'h0;
    @(posedge core_clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [3:0] ad[8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hD};
    foreach (ad[i]) begin
      bus(0, ad[i], 0);
      chk("reset value", q[7:0], 8'h00);
    end
    bus(1, OFS_IRQ_EN, 8'hFF);
    bus(0, OFS_IRQ_EN, 0);
    chk("irq enable rw", q[7:0], 8'h8F);
    bus(1, OFS_IRQ_EN, 8'h00);
    bus(1, OFS_PPR_LO, 8'h00);
    bus(1, OFS_PPR_HI, 8'hE0);
    bus(0, OFS_PPR_HI, 0);
    chk("pixels high", q[7:0], 8'h20);
    chk("pixels per row", pixels_per_row, 16'h2000);
    bus(1, OFS_FUNC, 8'hA5);
    bus(0, OFS_FUNC, 0);
    chk("function options", q[7:0], 8'hA5);
    chk("coding options", options, 8'h84);
    bus(0, 4'hE, 0);
    chk("unmapped read", q[7:0], 8'h00);
    $display("test registers done");
  endtask
  task automatic t_irq();
    int sb[4] = '{0, 1, 2, 4};
    for (int i = 0; i < 4; i++) begin
      core_status <= chr_status_t'(5'h01 << sb[i]);
      bus(1, OFS_IRQ_EN, 8'h0F & ~(8'h01 << i));
      chk("masked irq", irq_out, 1'b0);
      bus(1, OFS_IRQ_EN, 8'h01 << i);
      chk("irq raised", irq_out, 1'b1);
      bus(1, OFS_IRQ_EN, 8'h00);
      chk("irq masked off", irq_out, 1'b0);
      bus(0, OFS_STATUS, 0);
      chk("status kept", q[7:0], 8'h01 << sb[i]);
    end
    core_status <= '0;
    $display("test interrupts done");
  endtask
  task automatic t_halt();
    decoding <= 1'b1;
    bus(1, OFS_IRQ_EN, 8'h80);
    marker_code <= MARKER_ABORT;
    pulse(P_MARK);
    chk("halt on marker", halt_decode, 1'b1);
    bus(1, OFS_ROW_LO, 8'h05);
    bus(0, OFS_ROW_LO, 0);
    chk("row target while halted", q[7:0], 8'h05);
    chk("still halted", halt_decode, 1'b1);
    bus(0, OFS_MARKER, 0);
    chk("found marker", q[7:0], MARKER_ABORT);
    bus(1, OFS_IRQ_EN, 8'h00);
    chk("resume", halt_decode, 1'b0);
    decoding <= 1'b0;
    $display("test halt done");
  endtask
  task automatic t_rows();
    bus(1, OFS_ROW_LO, 8'hFF);
    bus(1, OFS_ROW_HI, 8'hFF);
    pulse(P_START);
    bus(1, OFS_ROW_LO, 8'h03);
    bus(1, OFS_ROW_HI, 8'h00);
    for (int i = 0; i < 3; i++) begin
      chk("rows not reached", rows_reached, 1'b0);
      pulse(P_ROW);
    end
    chk("rows reached", rows_reached, 1'b1);
    bus(0, OFS_DONE_LO, 0);
    chk("rows done", q[7:0], 8'h03);
    pulse(P_START);
    bus(0, OFS_DONE_LO, 0);
    chk("rows cleared", q[7:0], 8'h00);
    $display("test rows done");
  endtask
  task automatic t_stream();
    bus(1, OFS_MARKER, STRIPE_END_NORMAL);
    chk("end marker", end_marker_value, STRIPE_END_NORMAL);
    wide <= 1'b1;
    pulse(P_GO);
    for (int i = 0; i < 50 && code_valid; i++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    bus(0, OFS_BUF_LO, 0);
    chk("code word", q, 16'hA1A0);
    bus(0, OFS_BUF_LO, 0);
    chk("marker and pad", q, {PAD_BYTE, STRIPE_END_NORMAL});
    wide <= 1'b0;
    $display("test stream done");
  endtask
  task automatic t_skip();
    decoding <= 1'b1;
    first_stripe <= 1'b1;
    bus(1, OFS_FUNC, 8'hA3);
    chk("decode options", options, 8'hA3);
    pulse(P_START);
    chk("line clear at start", line_clear, 1'b1);
    bus(1, OFS_BUF_LO, 8'h11);
    chk("first byte dropped", wr_cnt, 16'h0000);
    bus(1, OFS_BUF_LO, 8'h5C);
    chk("second byte kept", wr_dat, 16'h005C);
    chk("one write per access", wr_cnt, 16'h0001);
    ctx <= 1'b1;
    wide <= 1'b1;
    bus(1, OFS_BUF_LO, 8'h96);
    chk("context low byte", wr_dat, 16'h0096);
    chk("context lanes", wr_ln, 2'b01);
    ctx <= 1'b0;
    wide <= 1'b0;
    decoding <= 1'b0;
    first_stripe <= 1'b0;
    core_status <= 5'h01;
    bus(1, OFS_IRQ_EN, 8'h01);
    chk("irq before reset", irq_out, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("irq in reset", irq_out, 1'b0);
    chk("line clear in reset", line_clear, 1'b1);
    srst <= 1'b0;
    @(posedge core_clk);
    bus(0, OFS_FUNC, 0);
    chk("options after reset", q[7:0], 8'h00);
    chk("irq after reset", irq_out, 1'b0);
    core_status <= '0;
    $display("test skip and reset done");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_irq();
    t_halt();
    t_rows();
    t_stream();
    t_skip();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
endmodule
